// ===== pmx_far_side.sv
// Purpose: Far-side circuits that share the multiplexed pins
// Assumes: Each outside circuit drives its pin while the device releases it
// Notes: Device drive wins; contention is not modelled
`timescale 1ns/1ps
`default_nettype none

module pmx_far_side (
	input wire pmx_pkg::pmx_pin_t pin_b,
	input wire pmx_pkg::pmx_pin_t pin_c,
	input wire logic ext_b,
	input wire logic ext_c,
	input wire logic ext_d,
	output logic lvl_b,
	output logic lvl_c,
	output logic lvl_d
);
	// ----------------------------------------------------------------
	// Pin level resolution
	// ----------------------------------------------------------------
	// Device enable decides who owns pins B and C
	assign lvl_b = pin_b.oe ? pin_b.out : ext_b;
	assign lvl_c = pin_c.oe ? pin_c.out : ext_c;
	assign lvl_d = ext_d; // Input only pin
endmodule // pmx_far_side

`default_nettype wire

// ===== pmx_pin_select.sv
// Purpose: Function select for four shared pins of an 8-bit processor
// Assumes: Single clock, synchronous active-high reset, APB register access
// Notes: Pin outputs and internal inputs are registered, one cycle late
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Reset makes pin A the upper address line
// - Either timer control bit gives pin A timer
// - Both timer bits clear return upper address
// - Reset makes pin B serial clock 0
// - Either DMA mode high bit selects request 0
// - Reset makes pin C serial clock 1
// - Clock-1 select set drives DMA end low-active
// - Clock-1 select clear gives serial clock 1
// - Reset makes pin D clocked serial receive
// - Send-enable bit set takes clear-to-send input
// - Send-enable bit clear takes clocked serial receive
module pmx_pin_select (
	input wire logic clock,
	input wire logic rst,
	input wire logic [pmx_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pmx_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [pmx_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic upper_address_line,
	input wire logic addr_oe,
	input wire logic timer_wave_output,
	input wire logic serial_clock_ch0_out,
	input wire logic serial_clock_ch0_oe,
	output logic serial_clock_ch0_in,
	output logic dma_request_ch0_n,
	input wire logic serial_clock_ch1_out,
	input wire logic serial_clock_ch1_oe,
	output logic serial_clock_ch1_in,
	input wire logic dma_end_ch0_n,
	output logic clocked_serial_receive,
	output logic clear_to_send_ch1_n,
	output pmx_pkg::pmx_pin_t pin_addr_timer,
	input wire logic pin_clk0_dreq_in,
	output pmx_pkg::pmx_pin_t pin_clk0_dreq,
	input wire logic pin_clk1_tend_in,
	output pmx_pkg::pmx_pin_t pin_clk1_tend,
	input wire logic pin_rx_cts_in
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Address match against a register offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// Place one bit at a field position of a read word
	function automatic logic [31:0] put(input int pos, input logic v);
		return (32'h0000_0001 << pos) & {32{v}};
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pmx_pkg::pmx_cfg_t cfg_reg;
	pmx_pkg::pmx_cfg_t cfg_next;
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	pmx_pkg::pmx_pin_t pin_a_reg, pin_a_next;
	pmx_pkg::pmx_pin_t pin_b_reg, pin_b_next;
	pmx_pkg::pmx_pin_t pin_c_reg, pin_c_next;
	logic sclk0_in_reg, sclk0_in_next;
	logic dreq_n_reg, dreq_n_next;
	logic sclk1_in_reg, sclk1_in_next;
	logic rx_reg, rx_next;
	logic cts_n_reg, cts_n_next;
	wire access;
	wire wr_en;
	wire sel_timer, sel_dma, sel_ser1a, sel_ser1s, sel_state;
	wire mapped;
	wire [31:0] rd_data;
	wire timer_sel, dreq_sel, tend_sel, cts_sel;
	wire act_timer, act_dreq, act_tend, act_cts;

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Address decode
	assign access = psel && penable;
	assign wr_en = access && pready_reg && pwrite && pstrb[0];
	assign sel_timer = hit(paddr, pmx_pkg::OFS_TIMER_CTRL);
	assign sel_dma = hit(paddr, pmx_pkg::OFS_DMA_MODE);
	assign sel_ser1a = hit(paddr, pmx_pkg::OFS_SER1_CTRL_A);
	assign sel_ser1s = hit(paddr, pmx_pkg::OFS_SER1_STATUS);
	assign sel_state = hit(paddr, pmx_pkg::OFS_PIN_STATE);
	assign mapped = sel_timer | sel_dma | sel_ser1a | sel_ser1s | sel_state;

	// Read data, unmapped words read zero
	assign rd_data =
		({32{sel_timer}} &
		(put(pmx_pkg::TOC_LOW_BIT, cfg_reg.toc_low) |
		put(pmx_pkg::TOC_HIGH_BIT, cfg_reg.toc_high))) |
		({32{sel_dma}} &
		(put(pmx_pkg::DEST_HI_BIT, cfg_reg.dest_hi) |
		put(pmx_pkg::SRC_HI_BIT, cfg_reg.src_hi))) |
		({32{sel_ser1a}} & put(pmx_pkg::CLK1_SEL_BIT, cfg_reg.clk1_sel)) |
		({32{sel_ser1s}} & put(pmx_pkg::CTS_EN_BIT, cfg_reg.cts_en)) |
		({32{sel_state}} &
		(put(pmx_pkg::ST_TIMER_BIT, timer_sel) |
		put(pmx_pkg::ST_DREQ_BIT, dreq_sel) |
		put(pmx_pkg::ST_TEND_BIT, tend_sel) |
		put(pmx_pkg::ST_CTS_BIT, cts_sel) |
		put(pmx_pkg::ST_PIN_B_BIT, pin_clk0_dreq_in) |
		put(pmx_pkg::ST_PIN_C_BIT, pin_clk1_tend_in) |
		put(pmx_pkg::ST_PIN_D_BIT, pin_rx_cts_in)));

	// Configuration writes, byte lane 0 carries every field
	assign cfg_next.toc_low = (wr_en && sel_timer) ?
		pwdata[pmx_pkg::TOC_LOW_BIT] : cfg_reg.toc_low;
	assign cfg_next.toc_high = (wr_en && sel_timer) ?
		pwdata[pmx_pkg::TOC_HIGH_BIT] : cfg_reg.toc_high;
	assign cfg_next.dest_hi = (wr_en && sel_dma) ?
		pwdata[pmx_pkg::DEST_HI_BIT] : cfg_reg.dest_hi;
	assign cfg_next.src_hi = (wr_en && sel_dma) ?
		pwdata[pmx_pkg::SRC_HI_BIT] : cfg_reg.src_hi;
	assign cfg_next.clk1_sel = (wr_en && sel_ser1a) ?
		pwdata[pmx_pkg::CLK1_SEL_BIT] : cfg_reg.clk1_sel;
	assign cfg_next.cts_en = (wr_en && sel_ser1s) ?
		pwdata[pmx_pkg::CTS_EN_BIT] : cfg_reg.cts_en;

	// One wait state: answer is captured, then the transfer completes
	always_ff @(posedge clock) begin
		if (rst) begin
			cfg_reg <= pmx_pkg::CFG_RESET;
			pready_reg <= 1'b0;
			prdata_reg <= pmx_pkg::DATA_ZERO;
			pslverr_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			pready_reg <= access && !pready_reg;
			if (access && !pready_reg) begin
				prdata_reg <= pwrite ? pmx_pkg::DATA_ZERO : rd_data;
				pslverr_reg <= !mapped;
			end
		end
	end

	assign pready = pready_reg;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;

	// ----------------------------------------------------------------
	// Function selection
	// ----------------------------------------------------------------
	// Selects from configuration, forced to primary while in reset
	assign timer_sel = cfg_reg.toc_high | cfg_reg.toc_low;
	assign dreq_sel = cfg_reg.dest_hi | cfg_reg.src_hi;
	assign tend_sel = cfg_reg.clk1_sel;
	assign cts_sel = cfg_reg.cts_en;
	assign act_timer = timer_sel && !rst;
	assign act_dreq = dreq_sel && !rst;
	assign act_tend = tend_sel && !rst;
	assign act_cts = cts_sel && !rst;

	// Pin A: address line or timer output
	assign pin_a_next.out = act_timer ?
		timer_wave_output : upper_address_line;
	assign pin_a_next.oe = act_timer ? 1'b1 : addr_oe;

	// Pin B: serial clock 0 or DMA request 0 input
	assign pin_b_next.out = act_dreq ? 1'b0 : serial_clock_ch0_out;
	assign pin_b_next.oe = act_dreq ? 1'b0 : serial_clock_ch0_oe;
	assign sclk0_in_next = act_dreq ?
		pmx_pkg::SCLK_IDLE : pin_clk0_dreq_in;
	assign dreq_n_next = act_dreq ?
		pin_clk0_dreq_in : pmx_pkg::ACT_LOW_IDLE;

	// Pin C: serial clock 1 or DMA end 0 output
	assign pin_c_next.out = act_tend ?
		dma_end_ch0_n : serial_clock_ch1_out;
	assign pin_c_next.oe = act_tend ? 1'b1 : serial_clock_ch1_oe;
	assign sclk1_in_next = act_tend ?
		pmx_pkg::SCLK_IDLE : pin_clk1_tend_in;

	// Pin D: clocked serial receive or clear-to-send 1 input
	assign rx_next = act_cts ?
		pmx_pkg::RX_IDLE : pin_rx_cts_in;
	assign cts_n_next = act_cts ?
		pin_rx_cts_in : pmx_pkg::ACT_LOW_IDLE;

	// Output and internal input flops
	always_ff @(posedge clock) begin
		pin_a_reg <= pin_a_next;
		pin_b_reg <= pin_b_next;
		pin_c_reg <= pin_c_next;
		sclk0_in_reg <= sclk0_in_next;
		dreq_n_reg <= dreq_n_next;
		sclk1_in_reg <= sclk1_in_next;
		rx_reg <= rx_next;
		cts_n_reg <= cts_n_next;
	end

	assign pin_addr_timer = pin_a_reg;
	assign pin_clk0_dreq = pin_b_reg;
	assign pin_clk1_tend = pin_c_reg;
	assign serial_clock_ch0_in = sclk0_in_reg;
	assign dma_request_ch0_n = dreq_n_reg;
	assign serial_clock_ch1_in = sclk1_in_reg;
	assign clocked_serial_receive = rx_reg;
	assign clear_to_send_ch1_n = cts_n_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Reset gives address line with its own enable
	AST_ADDR_RESET: assert property (@(posedge clock)
		rst |=> pin_addr_timer.out == $past(upper_address_line) &&
		pin_addr_timer.oe == $past(addr_oe))
		else $error("pin A not address line after reset");

	// Timer write reaches the pin two edges later
	AST_TIMER_SEL: assert property (@(posedge clock)
		disable iff (rst)
		wr_en && sel_timer && (pwdata[pmx_pkg::TOC_LOW_BIT] ||
		pwdata[pmx_pkg::TOC_HIGH_BIT])
		|=> timer_sel ##1 (pin_addr_timer.oe &&
		pin_addr_timer.out == $past(timer_wave_output)))
		else $error("timer output not on pin A");

	// Both timer bits clear gives the address line
	AST_ADDR_BACK: assert property (@(posedge clock)
		disable iff (rst)
		!timer_sel |=> pin_addr_timer.out == $past(upper_address_line))
		else $error("pin A not back to address line");

	// Reset gives serial clock 0 drive
	AST_CLK0_RESET: assert property (@(posedge clock)
		rst |=> pin_clk0_dreq.oe == $past(serial_clock_ch0_oe) &&
		dma_request_ch0_n == pmx_pkg::ACT_LOW_IDLE)
		else $error("pin B not serial clock 0 after reset");

	// DMA mode takes the pin as a request input
	AST_DREQ_SEL: assert property (@(posedge clock)
		disable iff (rst)
		dreq_sel |=> !pin_clk0_dreq.oe &&
		dma_request_ch0_n == $past(pin_clk0_dreq_in) &&
		serial_clock_ch0_in == pmx_pkg::SCLK_IDLE)
		else $error("DMA request 0 not selected");

	// Reset gives serial clock 1 drive
	AST_CLK1_RESET: assert property (@(posedge clock)
		rst |=> pin_clk1_tend.out == $past(serial_clock_ch1_out) &&
		pin_clk1_tend.oe == $past(serial_clock_ch1_oe))
		else $error("pin C not serial clock 1 after reset");

	// Clock-1 select drives DMA end on pin C
	AST_TEND_SEL: assert property (@(posedge clock)
		disable iff (rst)
		tend_sel |=> pin_clk1_tend.oe &&
		pin_clk1_tend.out == $past(dma_end_ch0_n))
		else $error("DMA end 0 not driven");

	// Clock-1 select clear passes pin C to serial clock 1
	AST_CLK1_SEL: assert property (@(posedge clock)
		disable iff (rst)
		!tend_sel |=> serial_clock_ch1_in == $past(pin_clk1_tend_in) &&
		pin_clk1_tend.out == $past(serial_clock_ch1_out))
		else $error("serial clock 1 not selected");

	// Reset gives clocked serial receive
	AST_RX_RESET: assert property (@(posedge clock)
		rst |=> clocked_serial_receive == $past(pin_rx_cts_in) &&
		clear_to_send_ch1_n == pmx_pkg::ACT_LOW_IDLE)
		else $error("pin D not receive after reset");

	// Send-enable bit routes pin D to clear-to-send
	AST_CTS_SEL: assert property (@(posedge clock)
		disable iff (rst)
		cts_sel |=> clear_to_send_ch1_n == $past(pin_rx_cts_in) &&
		clocked_serial_receive == pmx_pkg::RX_IDLE)
		else $error("clear-to-send 1 not selected");

	// Send-enable bit clear routes pin D to receive
	AST_RX_SEL: assert property (@(posedge clock)
		disable iff (rst)
		!cts_sel |=> clocked_serial_receive == $past(pin_rx_cts_in))
		else $error("receive not selected");

	// Mode bits clear gives clock 0 and an idle request
	AST_CLK0_SEL: assert property (@(posedge clock)
		disable iff (rst)
		!dreq_sel [*2] |-> dma_request_ch0_n == pmx_pkg::ACT_LOW_IDLE &&
		serial_clock_ch0_in == $past(pin_clk0_dreq_in))
		else $error("serial clock 0 not selected");

endmodule // pmx_pin_select

`default_nettype wire

// ===== pmx_pkg.sv
// Purpose: Shared constants and carrier types for the multiplexed pin select
// Assumes: APB slave with 32-bit data and one aligned word per register
// Notes: Offsets and bit positions are named here; the design uses them by name only
package pmx_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
	localparam logic [7:0] OFS_DMA_MODE = 8'h04;
	localparam logic [7:0] OFS_SER1_CTRL_A = 8'h08;
	localparam logic [7:0] OFS_SER1_STATUS = 8'h0C;
	localparam logic [7:0] OFS_PIN_STATE = 8'h10;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int TOC_LOW_BIT = 0;
	localparam int TOC_HIGH_BIT = 1;
	localparam int DEST_HI_BIT = 0;
	localparam int SRC_HI_BIT = 1;
	localparam int CLK1_SEL_BIT = 4;
	localparam int CTS_EN_BIT = 2;
	localparam int ST_TIMER_BIT = 0;
	localparam int ST_DREQ_BIT = 1;
	localparam int ST_TEND_BIT = 2;
	localparam int ST_CTS_BIT = 3;
	localparam int ST_PIN_B_BIT = 4;
	localparam int ST_PIN_C_BIT = 5;
	localparam int ST_PIN_D_BIT = 6;

	// ----------------------------------------------------------------
	// Reset and idle levels
	// ----------------------------------------------------------------
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
	localparam logic SCLK_IDLE = 1'b0;
	localparam logic RX_IDLE = 1'b1;
	localparam logic ACT_LOW_IDLE = 1'b1;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic toc_high;
		logic toc_low;
		logic dest_hi;
		logic src_hi;
		logic clk1_sel;
		logic cts_en;
	} pmx_cfg_t;

	localparam pmx_cfg_t CFG_RESET = '0;

	typedef struct packed {
		logic out;
		logic oe;
	} pmx_pin_t;

	localparam pmx_pin_t PIN_RESET = '0;

endpackage

// ===== test_multiplexed_pin_select.sv
// Purpose: Self-checking bench for the multiplexed pin select
// Assumes: Rows hold config, core and outside levels, expected pins
// Notes: Reset and refused accesses follow the table loop
`timescale 1ns/1ps
`default_nettype none

module test_multiplexed_pin_select;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hF;
	logic [10:0] stim = 11'h000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	pmx_pkg::pmx_pin_t pa;
	pmx_pkg::pmx_pin_t pb;
	pmx_pkg::pmx_pin_t pc;
	logic lb, lc, ld, ch0_in, dreq_n, ch1_in, rx_lvl, cts_n;
	logic [10:0] obs;
	logic [31:0] q;
	logic e;
	int fail_count = 0;
	int checks = 0;
	// Config, core and outside levels, expected pin outputs
	logic [27:0] rows [6] = '{28'h0346719, 28'h40BAEEF, 28'hA315245,
		28'h1DF9222, 28'h009886F, 28'hFC86E6B};

	assign obs = {pa, pb, pc, ch0_in, dreq_n, ch1_in, rx_lvl, cts_n};

	always #25 clock = ~clock;

	pmx_pin_select i_pmx_pin_select (.clock(clock), .rst(rst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .upper_address_line(stim[10]),
		.addr_oe(stim[9]), .timer_wave_output(stim[8]),
		.serial_clock_ch0_out(stim[7]), .serial_clock_ch0_oe(stim[6]),
		.serial_clock_ch0_in(ch0_in), .dma_request_ch0_n(dreq_n),
		.serial_clock_ch1_out(stim[5]), .serial_clock_ch1_oe(stim[4]),
		.serial_clock_ch1_in(ch1_in), .dma_end_ch0_n(stim[3]),
		.clocked_serial_receive(rx_lvl), .clear_to_send_ch1_n(cts_n),
		.pin_addr_timer(pa), .pin_clk0_dreq_in(lb), .pin_clk0_dreq(pb),
		.pin_clk1_tend_in(lc), .pin_clk1_tend(pc), .pin_rx_cts_in(ld));

	pmx_far_side i_pmx_far_side (.pin_b(pb), .pin_c(pc), .ext_b(stim[2]),
		.ext_c(stim[1]), .ext_d(stim[0]), .lvl_b(lb), .lvl_c(lc),
		.lvl_d(ld));

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	// One transfer; psel stays high so the next can follow at once
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rq, output logic re);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do @(posedge clock); while (pready !== 1'b1 && ++n < 20);
		if (n == 20) fail_count++;
		rq = prdata;
		re = pslverr;
		penable <= 1'b0;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask

	task set_cfg(input pmx_pkg::pmx_cfg_t c);
		apb(1'b1, pmx_pkg::OFS_TIMER_CTRL, {30'h0, c.toc_high, c.toc_low}, q, e);
		apb(1'b1, pmx_pkg::OFS_DMA_MODE, {30'h0, c.src_hi, c.dest_hi}, q, e);
		apb(1'b1, pmx_pkg::OFS_SER1_CTRL_A, {27'h0, c.clk1_sel, 4'h0}, q, e);
		apb(1'b1, pmx_pkg::OFS_SER1_STATUS, {29'h0, c.cts_en, 2'h0}, q, e);
		psel <= 1'b0;
	endtask

	task results();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	// Table rows, then refused accesses, then reset in mid-run
	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		for (int i = 0; i < 6; i++) begin
			set_cfg(rows[i][27:22]);
			stim <= rows[i][21:11];
			repeat (4) @(posedge clock);
			chk("pins", {21'h0, obs}, {21'h0, rows[i][10:0]});
			$display("row %0d done", i);
		end
		apb(1'b0, pmx_pkg::OFS_PIN_STATE, 32'h0000_0000, q, e);
		chk("pin state set", q, 32'h0000_007F);
		chk("state error", {31'h0, e}, 32'h0000_0000);
		apb(1'b0, 8'h20, 32'h0000_0000, q, e);
		chk("unmapped error", {31'h0, e}, 32'h0000_0001);
		chk("unmapped data", q, 32'h0000_0000);
		pstrb <= 4'h0;
		apb(1'b1, pmx_pkg::OFS_SER1_STATUS, 32'h0000_0000, q, e);
		pstrb <= 4'hF;
		apb(1'b0, pmx_pkg::OFS_SER1_STATUS, 32'h0000_0000, q, e);
		chk("status kept", q, 32'h0000_0004);
		apb(1'b0, pmx_pkg::OFS_SER1_CTRL_A, 32'h0000_0000, q, e);
		chk("ctrl a", q, 32'h0000_0010);
		psel <= 1'b0;
		$display("refusal test done");
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		chk("reset pins", {21'h0, obs}, 32'h0000_001B);
		rst <= 1'b0;
		@(posedge clock);
		apb(1'b0, pmx_pkg::OFS_DMA_MODE, 32'h0000_0000, q, e);
		chk("mode cleared", q, 32'h0000_0000);
		apb(1'b0, pmx_pkg::OFS_PIN_STATE, 32'h0000_0000, q, e);
		chk("pin state clear", q, 32'h0000_0050);
		psel <= 1'b0;
		$display("reset test done");
		results();
	end

	// Tests need some 125 cycles; far beyond that means a hang
	initial begin
		repeat (3000) @(posedge clock);
		fail_count++;
		results();
	end
endmodule // test_multiplexed_pin_select

`default_nettype wire
